// ==== fcsm_pkg.sv ====
package fcsm_pkg;

  // ==========================================================================
  // Command codes and unlock addresses (word addressing)
  // ==========================================================================
  localparam logic [10:0] FCSM_ADDR_UNLOCK1   = 11'h555;
  localparam logic [10:0] FCSM_ADDR_UNLOCK2   = 11'h2AA;
  localparam logic [7:0]  FCSM_DAT_UNLOCK1    = 8'hAA;
  localparam logic [7:0]  FCSM_DAT_UNLOCK2    = 8'h55;
  localparam logic [7:0]  FCSM_CMD_IDENT      = 8'h90;
  localparam logic [7:0]  FCSM_CMD_PROGRAM    = 8'hA0;
  localparam logic [7:0]  FCSM_CMD_ERASE_SET  = 8'h80;
  localparam logic [7:0]  FCSM_CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0]  FCSM_CMD_RESET      = 8'hF0;
  localparam logic [7:0]  FCSM_CMD_BYPASS     = 8'h20;
  localparam logic [7:0]  FCSM_CMD_BYP_EXIT2  = 8'h00;

  // ==========================================================================
  // Identification read addresses (low byte)
  // ==========================================================================
  localparam logic [7:0]  FCSM_ID_MAKER       = 8'h00;
  localparam logic [7:0]  FCSM_ID_DEVICE      = 8'h01;
  localparam logic [7:0]  FCSM_ID_PROTECT     = 8'h02;
  localparam logic [7:0]  FCSM_ID_CONTINUE    = 8'h11;

  // ==========================================================================
  // Bus timing in ns, 40 MHz clock
  // ==========================================================================
  localparam int FCSM_CLK_NS    = 25;
  localparam int FCSM_TWP_NS    = 50;
  localparam int FCSM_TWPH_NS   = 30;
  localparam int FCSM_TWP_CYC   = (FCSM_TWP_NS + FCSM_CLK_NS - 1) / FCSM_CLK_NS;
  localparam int FCSM_TWPH_CYC  = (FCSM_TWPH_NS + FCSM_CLK_NS - 1) / FCSM_CLK_NS;

  typedef enum logic [2:0] {
    FCSM_OP_READ,
    FCSM_OP_RESET,
    FCSM_OP_IDENT,
    FCSM_OP_PROGRAM,
    FCSM_OP_BYP_ENTER,
    FCSM_OP_BYP_PROGRAM,
    FCSM_OP_BYP_EXIT,
    FCSM_OP_CHIP_ERASE
  } fcsm_op_e;

  // Host request
  typedef struct packed {
    fcsm_op_e    op;
    logic [21:0] addr;
    logic [15:0] data;
  } fcsm_req_s;

  // One bus cycle on the flash pins
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
  } fcsm_cyc_s;

endpackage : fcsm_pkg

// ==== fcsm_host.sv ====
`timescale 1ns/1ps
module fcsm_host
  import fcsm_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire fcsm_req_s         req,
  input  wire logic              req_valid,
  output logic                   req_ready,
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  output logic                   busy_err,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DATA_W-1:0]      flash_dq_o,
  output logic                   flash_dq_oe,
  input  wire logic [DATA_W-1:0] flash_dq_i,
  input  wire logic              flash_ready,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n,
  output logic                   flash_reset_n
);

  if (ADDR_W != 22 || DATA_W != 16) begin : g_width_check
    $error("fcsm_host: widths fixed by package");
  end

  typedef enum logic [2:0] {
    FCSM_IDLE,
    FCSM_SETUP,
    FCSM_STROBE,
    FCSM_HOLD,
    FCSM_READ,
    FCSM_WAIT
  } fcsm_state_e;

  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] TWP_CNT  = CNT_W'(FCSM_TWP_CYC);
  localparam logic [CNT_W-1:0] TWPH_CNT = CNT_W'(FCSM_TWPH_CYC);
  localparam logic [2:0] ONE3 = 3'h1;

  // ==========================================================================
  // Command sequence table
  // ==========================================================================
  fcsm_state_e       state_reg, state_next;
  fcsm_req_s         cur_reg;
  logic [2:0]        idx_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [2:0]        len_w;
  fcsm_cyc_s         cyc_w;
  fcsm_cyc_s         unl1_w, unl2_w;

  assign unl1_w = '{addr: {11'h000, FCSM_ADDR_UNLOCK1}, data: {8'h00, FCSM_DAT_UNLOCK1}};
  assign unl2_w = '{addr: {11'h000, FCSM_ADDR_UNLOCK2}, data: {8'h00, FCSM_DAT_UNLOCK2}};

  // Number of write cycles per operation
  assign len_w = (cur_reg.op == FCSM_OP_PROGRAM)     ? 3'h4 :
                 (cur_reg.op == FCSM_OP_CHIP_ERASE)  ? 3'h6 :
                 (cur_reg.op == FCSM_OP_IDENT)       ? 3'h3 :
                 (cur_reg.op == FCSM_OP_BYP_ENTER)   ? 3'h3 :
                 (cur_reg.op == FCSM_OP_BYP_PROGRAM) ? 3'h2 :
                 (cur_reg.op == FCSM_OP_BYP_EXIT)    ? 3'h2 :
                 3'h1;

  wire fcsm_cyc_s cmd_w =
    '{addr: {11'h000, FCSM_ADDR_UNLOCK1},
      data: {8'h00, (cur_reg.op == FCSM_OP_PROGRAM)   ? FCSM_CMD_PROGRAM   :
                    (cur_reg.op == FCSM_OP_IDENT)     ? FCSM_CMD_IDENT     :
                    (cur_reg.op == FCSM_OP_BYP_ENTER) ? FCSM_CMD_BYPASS    :
                    FCSM_CMD_ERASE_SET}};
  wire fcsm_cyc_s tgt_w = '{addr: cur_reg.addr, data: cur_reg.data};

  always_comb begin
    cyc_w = '{addr: '0, data: {8'h00, FCSM_CMD_RESET}};
    unique case (cur_reg.op)
      FCSM_OP_PROGRAM, FCSM_OP_IDENT, FCSM_OP_BYP_ENTER: begin
        cyc_w = (idx_reg == 3'h0) ? unl1_w : (idx_reg == 3'h1) ? unl2_w :
                (idx_reg == 3'h2) ? cmd_w : tgt_w;
      end
      FCSM_OP_CHIP_ERASE: begin
        cyc_w = (idx_reg == 3'h0 || idx_reg == 3'h3) ? unl1_w :
                (idx_reg == 3'h1 || idx_reg == 3'h4) ? unl2_w :
                (idx_reg == 3'h2) ? cmd_w :
                '{addr: {11'h000, FCSM_ADDR_UNLOCK1},
                  data: {8'h00, FCSM_CMD_CHIP_ERASE}};
      end
      FCSM_OP_BYP_PROGRAM: begin
        cyc_w = (idx_reg == 3'h0) ?
                '{addr: '0, data: {8'h00, FCSM_CMD_PROGRAM}} : tgt_w;
      end
      FCSM_OP_BYP_EXIT: begin
        cyc_w = (idx_reg == 3'h0) ? '{addr: '0, data: {8'h00, FCSM_CMD_IDENT}} :
                '{addr: '0, data: {8'h00, FCSM_CMD_BYP_EXIT2}};
      end
      default: begin
        cyc_w = '{addr: '0, data: {8'h00, FCSM_CMD_RESET}};
      end
    endcase
  end

  // ==========================================================================
  // Bus cycle sequencer
  // ==========================================================================
  wire cnt_done = (cnt_reg == '0);
  wire last_cyc = (idx_reg == len_w - ONE3);
  wire waits    = (cur_reg.op == FCSM_OP_PROGRAM) || (cur_reg.op == FCSM_OP_CHIP_ERASE) ||
                  (cur_reg.op == FCSM_OP_BYP_PROGRAM);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FCSM_IDLE:   if (req_valid) state_next = FCSM_SETUP;
      FCSM_SETUP:  state_next = (cur_reg.op == FCSM_OP_READ) ? FCSM_READ : FCSM_STROBE;
      FCSM_STROBE: if (cnt_done) state_next = FCSM_HOLD;
      FCSM_HOLD:   if (cnt_done) state_next = !last_cyc ? FCSM_SETUP :
                                              waits ? FCSM_WAIT : FCSM_IDLE;
      FCSM_READ:   if (cnt_done) state_next = FCSM_IDLE;
      FCSM_WAIT:   if (flash_ready) state_next = FCSM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= FCSM_IDLE;
      cur_reg   <= '0;
      idx_reg   <= '0;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == FCSM_IDLE && req_valid) cur_reg <= req;
      if (state_reg == FCSM_IDLE) idx_reg <= '0;
      else if (state_reg == FCSM_HOLD && cnt_done) idx_reg <= idx_reg + ONE3;
      cnt_reg <= (state_next == FCSM_STROBE && state_reg != FCSM_STROBE) ? TWP_CNT :
                 (state_next == FCSM_HOLD && state_reg != FCSM_HOLD) ? TWPH_CNT :
                 (state_next == FCSM_READ && state_reg != FCSM_READ) ? TWP_CNT :
                 cnt_done ? cnt_reg : cnt_reg - 1'b1;
    end
  end

  // ==========================================================================
  // Pin drivers, all registered
  // ==========================================================================
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flash_addr    <= '0;
      flash_dq_o    <= '0;
      flash_dq_oe   <= 1'b0;
      flash_ce_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_reset_n <= 1'b0;
      req_ready     <= 1'b0;
      rd_valid      <= 1'b0;
      rd_data       <= '0;
      busy_err      <= 1'b0;
    end else begin
      flash_reset_n <= 1'b1;
      req_ready     <= (state_next == FCSM_IDLE);
      rd_valid      <= (state_reg == FCSM_READ) && cnt_done;
      busy_err      <= (state_reg == FCSM_WAIT) && req_valid;
      if (state_reg == FCSM_READ && cnt_done) rd_data <= flash_dq_i;
      if (state_next == FCSM_SETUP) begin
        flash_addr <= (state_reg == FCSM_IDLE && req.op == FCSM_OP_READ) ? req.addr :
                      (cur_reg.op == FCSM_OP_READ) ? cur_reg.addr : flash_addr;
      end
      if (state_reg == FCSM_SETUP && cur_reg.op != FCSM_OP_READ) begin
        flash_addr  <= cyc_w.addr;
        flash_dq_o  <= cyc_w.data;
        flash_dq_oe <= 1'b1;
      end
      if (state_reg == FCSM_SETUP && cur_reg.op == FCSM_OP_READ) flash_addr <= cur_reg.addr;
      flash_ce_n <= !(state_next == FCSM_STROBE || state_next == FCSM_HOLD ||
                      state_next == FCSM_READ);
      flash_we_n <= !(state_next == FCSM_STROBE);
      flash_oe_n <= !(state_next == FCSM_READ);
      if (state_next == FCSM_IDLE || state_next == FCSM_WAIT) flash_dq_oe <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic [2:0] wr_cnt_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) wr_cnt_reg <= '0;
    else if (state_reg == FCSM_IDLE) wr_cnt_reg <= '0;
    else if ($rose(flash_we_n)) wr_cnt_reg <= wr_cnt_reg + ONE3;
  end

  AST_WE_PULSE_WIDTH: assert property (@(posedge clk) disable iff (!rstn)
    $fell(flash_we_n) |-> !flash_we_n[*2])
    else $error("write strobe pulse too short");
  AST_CE_WITH_WE: assert property (@(posedge clk) disable iff (!rstn)
    !flash_we_n |-> !flash_ce_n && flash_dq_oe)
    else $error("write strobe without chip enable");
  AST_PROG_FOUR: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == FCSM_WAIT && cur_reg.op == FCSM_OP_PROGRAM) |-> wr_cnt_reg == 3'h4)
    else $error("program not four writes");
  AST_ERASE_SIX: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == FCSM_WAIT && cur_reg.op == FCSM_OP_CHIP_ERASE) |-> wr_cnt_reg == 3'h6)
    else $error("chip erase not six writes");
  AST_BYP_TWO: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == FCSM_WAIT && cur_reg.op == FCSM_OP_BYP_PROGRAM) |-> wr_cnt_reg == 3'h2)
    else $error("bypass program not two writes");
  AST_NO_WRITE_BUSY: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == FCSM_WAIT |-> flash_we_n)
    else $error("write while flash busy");
  AST_FIRST_UNLOCK: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == FCSM_SETUP && idx_reg == 3'h0 && cur_reg.op == FCSM_OP_PROGRAM)
      |=> flash_dq_o[7:0] == FCSM_DAT_UNLOCK1 && flash_addr[10:0] == FCSM_ADDR_UNLOCK1)
    else $error("wrong first unlock");
  AST_READ_DONE: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == FCSM_SETUP && cur_reg.op == FCSM_OP_READ) |-> ##[1:6] rd_valid)
    else $error("read not answered");
  AST_RESET_ONE: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == FCSM_HOLD && cur_reg.op == FCSM_OP_RESET) |-> last_cyc)
    else $error("reset not single cycle");

  COV_PROG: cover property (@(posedge clk) disable iff (!rstn)
    state_reg == FCSM_WAIT && cur_reg.op == FCSM_OP_PROGRAM);
  COV_ERASE: cover property (@(posedge clk) disable iff (!rstn)
    state_reg == FCSM_WAIT && cur_reg.op == FCSM_OP_CHIP_ERASE);
  COV_READ: cover property (@(posedge clk) disable iff (!rstn) rd_valid);
  COV_BYP_EXIT: cover property (@(posedge clk) disable iff (!rstn)
    state_reg == FCSM_HOLD && cur_reg.op == FCSM_OP_BYP_EXIT && last_cyc);

endmodule // fcsm_host

// ==== fcsm_flash_model.sv ====
`timescale 1ns/1ps
module fcsm_flash_model
  import fcsm_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'h005A, // Arbitrary value
  parameter logic [15:0] DEV_CODE   = 16'h1234, // Arbitrary value
  parameter logic [15:0] CONT_CODE  = 16'h007F  // Arbitrary value
) (
  input  wire logic [21:0] addr,
  input  wire logic [15:0] din,
  output logic      [15:0] dout,
  output logic             rdy,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        reset_n,
  input  wire integer      busy_ns
);
  typedef enum int {RD, U1, U2, ID, PS, E1, E2, E3, BY, BP, BX, BU} fcsm_mst_e;
  logic [15:0] mem [int];
  fcsm_mst_e   st    = RD;
  logic [21:0] la;
  logic [15:0] last  = 16'h0000;
  int          gen   = 0;
  wire         wr    = !ce_n && !we_n;
  wire         rd_on = !ce_n && !oe_n;
  localparam logic [10:0] UA = FCSM_ADDR_UNLOCK1;
  localparam logic [10:0] UB = FCSM_ADDR_UNLOCK2;

  function automatic bit hit(input logic [10:0] x, input logic [7:0] y);
    return la[10:0] == x && din[7:0] == y;
  endfunction

  function automatic logic [15:0] rv(input logic [21:0] x);
    if (st == BU) return ~last;
    if (st != ID) return mem.exists(int'(x)) ? mem[int'(x)] : 16'hFFFF;
    case (x[7:0])
      FCSM_ID_MAKER:    return MAKER_CODE;
      FCSM_ID_DEVICE:   return DEV_CODE;
      FCSM_ID_CONTINUE: return CONT_CODE;
      FCSM_ID_PROTECT:  return {15'h0000, x[21]};
      default:          return 16'h0000;
    endcase
  endfunction

  // Self-timed algorithm; a newer generation cancels it
  task automatic run(input fcsm_mst_e nx, input bit er, input logic [21:0] x,
                     input logic [15:0] y);
    int          g;
    logic [15:0] nv;
    nv = rv(x) & y;
    gen = gen + 1;
    g = gen;
    st = BU;
    rdy = 1'h0;
    fork
      begin
        #(busy_ns);
        if (g == gen) begin
          if (er) mem.delete();
          else mem[int'(x)] = nv;
          st = nx;
          rdy = 1'h1;
        end
      end
    join_none
  endtask

  initial rdy = 1'h1;

  always @(negedge reset_n) begin
    gen = gen + 1;
    st = RD;
    rdy = 1'h1;
  end

  always @(posedge wr) la = addr;

  // ==========================================================================
  // Command decode at every falling edge of wr (rising we_n)
  // ==========================================================================
  always @(negedge wr) begin
    if (reset_n) begin
      case (st)
        RD: st = hit(UA, FCSM_DAT_UNLOCK1) ? U1 : RD;
        U1: st = hit(UB, FCSM_DAT_UNLOCK2) ? U2 : RD;
        U2: st = hit(UA, FCSM_CMD_IDENT) ? ID : hit(UA, FCSM_CMD_PROGRAM) ? PS :
                 hit(UA, FCSM_CMD_ERASE_SET) ? E1 : hit(UA, FCSM_CMD_BYPASS) ? BY : RD;
        ID: st = (din[7:0] == FCSM_CMD_RESET) ? RD : ID;
        PS: run(RD, 1'b0, la, din);
        E1: st = hit(UA, FCSM_DAT_UNLOCK1) ? E2 : RD;
        E2: st = hit(UB, FCSM_DAT_UNLOCK2) ? E3 : RD;
        E3: if (hit(UA, FCSM_CMD_CHIP_ERASE)) run(RD, 1'b1, la, din); else st = RD;
        BY: st = din[7:0] == FCSM_CMD_PROGRAM ? BP : din[7:0] == FCSM_CMD_IDENT ? BX : BY;
        BP: run(BY, 1'b0, la, din);
        BX: st = din[7:0] == FCSM_CMD_BYP_EXIT2 ? RD : BY;
        default: ;
      endcase
    end
  end

  // Released bus shows the inverse of the last driven value
  always #2 begin
    dout = rd_on ? rv(addr) : ~last;
    if (rd_on) last = dout;
  end
endmodule // fcsm_flash_model

// ==== tb_flash_command_state_machine.sv ====
`timescale 1ns/1ps
module tb_flash_command_state_machine
  import fcsm_pkg::*;
;
  localparam logic [15:0] MK = 16'h005A; // Arbitrary value
  localparam logic [15:0] DV = 16'h1234; // Arbitrary value
  localparam logic [15:0] CT = 16'h007F; // Arbitrary value
  logic        clk = 1'h0;
  logic        rstn, req_valid, req_ready, rd_valid, busy_err, seen;
  fcsm_req_s   req;
  logic [15:0] rd_data, flash_dq_o, mdq, got, d;
  logic [21:0] flash_addr, a;
  logic        flash_dq_oe, flash_ready, flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n;
  logic [15:0] exp_mem [int];
  logic [21:0] aq [$];
  int          mismatches = 0, n_checks = 0, cycles = 0, busy_ns = 300, i;
  integer      seed = 32'h56E4039F;
  wire  [15:0] flash_dq_i = flash_dq_oe ? flash_dq_o : mdq;

  always #12.5 clk = ~clk;

  fcsm_host dut_u (.clk, .rstn, .req, .req_valid, .req_ready, .rd_valid, .rd_data, .busy_err,
    .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i, .flash_ready, .flash_ce_n,
    .flash_we_n, .flash_oe_n, .flash_reset_n);
  fcsm_flash_model #(.MAKER_CODE(MK), .DEV_CODE(DV), .CONT_CODE(CT)) mdl_u (
    .addr(flash_addr), .din(flash_dq_o), .dout(mdq), .rdy(flash_ready), .ce_n(flash_ce_n),
    .we_n(flash_we_n), .oe_n(flash_oe_n), .reset_n(flash_reset_n), .busy_ns(busy_ns));

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      close_out();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  function automatic logic [15:0] ev(input logic [21:0] x);
    return exp_mem.exists(int'(x)) ? exp_mem[int'(x)] : 16'hFFFF;
  endfunction

  task automatic op(input fcsm_op_e o, input logic [21:0] x, input logic [15:0] y);
    repeat (4000) if (req_ready !== 1'h1) @(negedge clk);
    req = '{o, x, y};
    req_valid = 1'h1;
    @(negedge clk);
    req_valid = 1'h0;
    if (o == FCSM_OP_READ) begin
      repeat (40) if (rd_valid !== 1'h1) @(negedge clk);
      got = (rd_valid === 1'h1) ? rd_data : 'x;
    end
    @(negedge clk);
  endtask

  task automatic prog(input fcsm_op_e o, input logic [21:0] x, input logic [15:0] y);
    exp_mem[int'(x)] = ev(x) & y;
    op(o, x, y);
  endtask

  task automatic rdi(input logic [21:0] x, input logic [15:0] e);
    op(FCSM_OP_READ, x, 16'h0000);
    check(got, e);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rstn = 1'h0;
    req = '0;
    req_valid = 1'h0;
    repeat (2) @(negedge clk);
    rstn = 1'h1;
    @(negedge clk);
    check(16'(flash_reset_n), 16'h0001);
    rdi(22'h000123, 16'hFFFF);
    $display("end power-up");
    for (i = 0; i < 6; i++) begin
      a = 22'($random(seed));
      d = 16'($random(seed));
      prog(FCSM_OP_PROGRAM, a, d);
      rdi(a, ev(a));
    end
    prog(FCSM_OP_PROGRAM, a, 16'hFFFF);
    rdi(a, ev(a));
    $display("end program");
    op(FCSM_OP_IDENT, 22'h000000, 16'h0000);
    for (i = 0; i < 2; i++) begin
      rdi(22'h3A5500, MK);
      rdi(22'h000011, CT);
      rdi(22'h1F0001, DV);
      rdi(22'h200002, 16'h0001);
      rdi(22'h100002, 16'h0000);
    end
    op(FCSM_OP_RESET, 22'($random(seed)), 16'h0000);
    rdi(a, ev(a));
    $display("end ident");
    op(FCSM_OP_BYP_ENTER, 22'h000000, 16'h0000);
    for (i = 0; i < 3; i++) begin
      aq.push_back(22'($random(seed)));
      prog(FCSM_OP_BYP_PROGRAM, aq[i], 16'($random(seed)));
    end
    op(FCSM_OP_BYP_EXIT, 22'($random(seed)), 16'h0000);
    foreach (aq[j]) rdi(aq[j], ev(aq[j]));
    $display("end bypass");
    busy_ns = 5000;
    prog(FCSM_OP_PROGRAM, aq[0], 16'h0000);
    repeat (40) @(negedge clk);
    req = '{FCSM_OP_READ, aq[0], 16'h0000};
    req_valid = 1'h1;
    seen = 1'h0;
    repeat (20) begin
      @(negedge clk);
      if (busy_err === 1'h1) seen = 1'h1;
    end
    check(16'(seen), 16'h0001);
    rstn = 1'h0;
    req_valid = 1'h0;
    @(negedge clk);
    check(16'(flash_reset_n), 16'h0000);
    rstn = 1'h1;
    busy_ns = 300;
    prog(FCSM_OP_PROGRAM, aq[0], 16'h0000);
    rdi(aq[0], 16'h0000);
    $display("end hardware reset");
    op(FCSM_OP_CHIP_ERASE, 22'h000000, 16'h0000);
    exp_mem.delete();
    rdi(aq[0], 16'hFFFF);
    rdi(a, ev(a));
    $display("end erase");
    close_out();
  end
endmodule // tb_flash_command_state_machine
